// *** verilog/vdec_irq_pkg.sv ***
/*
  Shared constants of the video decoder interrupt flag block: bus widths,
  register map, flag bit positions and reset values.
  Assumes one clock domain and a 32-bit Avalon-MM slave port.
*/
`default_nettype none
package vdec_irq_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 6;   // Byte address width of the slave
  localparam int DATA_W   = 32;  // Avalon data width
  localparam int REG_W    = 8;   // Width of each status or mask register
  localparam int NUM_REGS = 4;   // Status registers in the block
  localparam int FLAG_W   = REG_W * NUM_REGS;

  // ----------------------------------------------------------------
  // Register map: address[5:4] selects the group, [3:2] the register
  // ----------------------------------------------------------------
  localparam logic [1:0] GRP_STATUS = 2'h0;  // 0x00..0x0C live state, read clears
  localparam logic [1:0] GRP_PEND   = 2'h1;  // 0x10..0x1C pending flags, no side effect
  localparam logic [1:0] GRP_MASK   = 2'h2;  // 0x20..0x2C flag enables, read/write

  // ----------------------------------------------------------------
  // Flag positions inside the 32-bit flag vector (register*8 + bit)
  // ----------------------------------------------------------------
  localparam int BIT_INTERLACE = 0;   // Register 0, decoder
  localparam int BIT_HLOCK     = 1;
  localparam int BIT_VLOCK     = 2;
  localparam int BIT_FIELD     = 3;
  localparam int BIT_CAPREADY  = 4;
  localparam int BIT_COLOUR    = 5;   // Two bits, 5 and 6
  localparam int BIT_POWER     = 7;
  localparam int BIT_COPY_A    = 8;   // Register 1, copy protection
  localparam int BIT_COPY_B    = 9;
  localparam int BIT_COPY_C    = 10;
  localparam int BIT_VPS       = 16;  // Register 2, VBI slicer
  localparam int BIT_WIDE      = 17;
  localparam int BIT_CAPTION   = 18;
  localparam int BIT_SCALER    = 24;  // Register 3, scaler

  // Sources that flag on a rising edge only; all others flag on any change
  localparam logic [FLAG_W-1:0] RISE_ONLY = 32'h0100_0080;
  // Bits that carry a flag at all; the rest read as zero
  localparam logic [FLAG_W-1:0] USED_BITS = 32'h0107_07FF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0]  MASK_RST  = 8'h00;         // All sources disabled
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
endpackage
`default_nettype wire

// *** verilog/flag_bank.sv ***
/*
  Bank of sticky event flags. Each bit latches a change (or a rise) of
  its source level and is cleared by a strobe; a set in the same cycle wins.
  Assumes source levels come from logic on the same clock.
*/
`default_nettype none
module flag_bank #(
  parameter int           W         = 32,
  parameter logic [W-1:0] RISE_MASK = '0,
  parameter logic [W-1:0] USED_MASK = '1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // Sources and clear strobes
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] clr,
  // Flags and the registered live levels
  output logic      [W-1:0] flags,
  output logic      [W-1:0] levelQ,
  output logic              primed
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic         primed;  // First sample taken, edges now meaningful
    logic [W-1:0] prev;    // Last sampled level
    logic [W-1:0] flag;    // Sticky flags
  } bank_t;

  bank_t cur_ff;
  bank_t nxt_cur;

  // Edge detect and sticky update; set beats clear
  always_comb begin
    logic [W-1:0] setEv;
    setEv = '0;
    nxt_cur = cur_ff;
    // No events until a first sample exists, so reset does not fake a change
    if (cur_ff.primed) begin
      setEv = (((level ^ cur_ff.prev) & ~RISE_MASK) |
               (level & ~cur_ff.prev & RISE_MASK)) & USED_MASK;
    end
    nxt_cur.flag   = (cur_ff.flag & ~clr) | setEv;
    nxt_cur.prev   = level & USED_MASK;
    nxt_cur.primed = 1'b1;
  end

  // State register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign flags  = cur_ff.flag;
  assign levelQ = cur_ff.prev;
  assign primed = cur_ff.primed;
endmodule
`default_nettype wire

// *** verilog/vdec_irq_flags.sv ***
/*
  Interrupt flag logic of the video decoder: event sources set sticky
  flags in four 8-bit groups, per-flag enables gate them onto an
  active-low open-drain request pin, and reading a status register
  returns the live state and clears that register's flags.
  Assumes sources are levels from decoder logic on clk, and a host on
  Avalon-MM with waitrequest.
*/
`default_nettype none

// Overview of operation
// - Request pin open-drain, pulled low when an enabled flag is pending
// - Every flag has its own enable
// - All enables cleared by reset
// - Power fail sets power flag
// - Interlace detection change sets flag
// - Horizontal lock change sets flag
// - Vertical lock change sets flag
// - Field rate change sets flag
// - Capture readiness toggle sets flag
// - Colour standard change sets two-bit field
// - Copy protection changes set three flags
// - VPS identification change sets flag
// - Widescreen identification change sets flag
// - Caption identification change sets flag
// - Scaler format error sets flag
// - Status read returns live condition
// - Flags sit in four 8-bit registers
// - Only reading its register clears flag
// - New trigger on the clearing edge keeps flag
module vdec_irq_flags (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst_n,

  // Avalon-MM slave
  input  wire logic [vdec_irq_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [vdec_irq_pkg::DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]                         avs_byteenable,
  output logic      [vdec_irq_pkg::DATA_W-1:0]    avs_readdata,
  output logic                                    avs_waitrequest,

  // Power monitor
  input  wire logic                               powerFail,

  // Decoder sync and standard detection
  input  wire logic                               interlaced,
  input  wire logic                               horizLocked,
  input  wire logic                               vertLocked,
  input  wire logic                               field60Hz,
  input  wire logic                               captureReady,
  input  wire logic [1:0]                         colourStandard,

  // Copy-protection detection
  input  wire logic [2:0]                         copyProtLevel,

  // VBI slicer
  input  wire logic                               vpsFound,
  input  wire logic                               widescreenFound,
  input  wire logic                               captionFound,

  // Scaler
  input  wire logic                               scalerFormatError,

  // Open-drain interrupt pin, active low
  output logic                                    irqPinOut,
  output logic                                    irqPinOe
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rstMeta_ff;  // First stage, read only by the second
  logic rstSync_ff;  // Released copy used by the whole block

  // Assert at once, release two edges later
  // A raw release near an edge could free some flops a cycle before others;
  // two stages give the first one a full cycle to settle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Flag vector assembly
  // ----------------------------------------------------------------
  logic [vdec_irq_pkg::FLAG_W-1:0] levelVec;  // Source levels in register layout
  logic [vdec_irq_pkg::FLAG_W-1:0] clrVec;    // Clear strobes per flag
  logic [vdec_irq_pkg::FLAG_W-1:0] flags;     // Sticky flags
  logic [vdec_irq_pkg::FLAG_W-1:0] liveQ;     // Registered live levels
  logic                            bankReady; // Bank has a first sample

  // Each source goes to its fixed place in the four registers
  // Unused places stay zero; colour takes two, copy protection three
  always_comb begin
    levelVec = '0;
    levelVec[vdec_irq_pkg::BIT_POWER]        = powerFail;
    levelVec[vdec_irq_pkg::BIT_INTERLACE]    = interlaced;
    levelVec[vdec_irq_pkg::BIT_HLOCK]        = horizLocked;
    levelVec[vdec_irq_pkg::BIT_VLOCK]        = vertLocked;
    levelVec[vdec_irq_pkg::BIT_FIELD]        = field60Hz;
    levelVec[vdec_irq_pkg::BIT_CAPREADY]     = captureReady;
    levelVec[vdec_irq_pkg::BIT_COLOUR +: 2]  = colourStandard;
    levelVec[vdec_irq_pkg::BIT_COPY_A +: 3]  = copyProtLevel;
    levelVec[vdec_irq_pkg::BIT_VPS]          = vpsFound;
    levelVec[vdec_irq_pkg::BIT_WIDE]         = widescreenFound;
    levelVec[vdec_irq_pkg::BIT_CAPTION]      = captionFound;
    levelVec[vdec_irq_pkg::BIT_SCALER]       = scalerFormatError;
  end

  // Sticky flags; power and scaler flag on rise, others on any change
  // A falling power or scaler level is recovery, not news
  // Sources are same-clock logic, so no synchroniser stands in front
  flag_bank #(
    .W         (vdec_irq_pkg::FLAG_W),
    .RISE_MASK (vdec_irq_pkg::RISE_ONLY),
    .USED_MASK (vdec_irq_pkg::USED_BITS)
  ) u_flags (
    .clk    (clk),
    .rstN   (rstSync_ff),
    .level  (levelVec),
    .clr    (clrVec),
    .flags  (flags),
    .levelQ (liveQ),
    .primed (bankReady)
  );

  // ----------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------
  // Enables sit beside the bus state because only the bus writes them
  typedef struct packed {
    logic                                ack;    // Second cycle of an access
    logic [vdec_irq_pkg::DATA_W-1:0]     rdata;  // Read data register
    logic [vdec_irq_pkg::FLAG_W-1:0]     mask;   // Per-flag enables
    logic                                irqOe;  // Pin pulled low
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // Two-phase access: taken on the first cycle, done on the second
  // Decode helpers
  logic       req;      // Any request present
  logic       taken;    // First cycle of a request
  logic       done;     // Completing cycle, waitrequest low
  logic [1:0] grp;      // Register group
  logic [1:0] idx;      // Register within group
  logic       aligned;  // Word-aligned address

  assign req     = avs_read | avs_write;
  assign taken   = req & ~st_ff.ack;
  assign done    = req & st_ff.ack;
  assign grp     = avs_address[5:4];
  assign idx     = avs_address[3:2];
  assign aligned = (avs_address[1:0] == 2'h0);

  // One wait state on every access gives the read data a register stage
  // Cost: every access takes two cycles, but readdata never comes from a mux
  assign avs_waitrequest = taken;

  // Clear strobes: only a completed read of a status register
  // Pending and enable reads have no side effect, so software may poll them
  always_comb begin
    clrVec = '0;
    if (done && avs_read && aligned && grp == vdec_irq_pkg::GRP_STATUS) begin
      clrVec[idx*vdec_irq_pkg::REG_W +: vdec_irq_pkg::REG_W] = 8'hFF;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Bus side and pin side share one struct, so all state moves on one edge
  always_comb begin
    logic [vdec_irq_pkg::REG_W-1:0] rsel;
    rsel = '0;
    nxt_st = st_ff;
    nxt_st.ack = taken;
    // Read data is fetched on the first cycle and stands at completion
    if (taken && avs_read && aligned) begin
      case (grp)
        // Live state, not a copy frozen at the event
        vdec_irq_pkg::GRP_STATUS: rsel = liveQ[idx*vdec_irq_pkg::REG_W +: vdec_irq_pkg::REG_W];
        vdec_irq_pkg::GRP_PEND:   rsel = flags[idx*vdec_irq_pkg::REG_W +: vdec_irq_pkg::REG_W];
        vdec_irq_pkg::GRP_MASK:   rsel = st_ff.mask[idx*vdec_irq_pkg::REG_W +: vdec_irq_pkg::REG_W];
        default:                  rsel = '0;  // Unmapped reads return zero
      endcase
      nxt_st.rdata = {24'h00_0000, rsel};
    end else if (taken && avs_read) begin
      nxt_st.rdata = vdec_irq_pkg::RDATA_RST;
    end

    // Enables change only on a completed mask write with lane 0 set
    if (done && avs_write && aligned && avs_byteenable[0] &&
        grp == vdec_irq_pkg::GRP_MASK) begin
      nxt_st.mask[idx*vdec_irq_pkg::REG_W +: vdec_irq_pkg::REG_W] =
        avs_writedata[vdec_irq_pkg::REG_W-1:0];
    end

    // Unused enable bits are held at zero so they read back clean
    nxt_st.mask = nxt_st.mask & vdec_irq_pkg::USED_BITS;

    // Pin follows any enabled pending flag, one cycle later
    // Registered so the pin cannot glitch while flags and enables settle
    nxt_st.irqOe = |(flags & st_ff.mask);
  end

  // State register; enables come up disabled
  // Reset lists the fields one by one, each given a constant
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      st_ff.ack   <= 1'b0;
      st_ff.rdata <= vdec_irq_pkg::RDATA_RST;
      st_ff.mask  <= {vdec_irq_pkg::NUM_REGS{vdec_irq_pkg::MASK_RST}};
      st_ff.irqOe <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = st_ff.rdata;
  // Open drain: the driven value is always low, only the enable moves
  // The released level comes from a pull-up outside the block
  assign irqPinOut = 1'b0;
  assign irqPinOe  = st_ff.irqOe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_ff);
  // The bank's first sample is never judged: the source checks require $past(bankReady)

  // A status read of register r in its taken cycle
  sequence seq_status_take(int r);
    taken && avs_read && aligned && grp == vdec_irq_pkg::GRP_STATUS && idx == r;
  endsequence
  // The completing cycle of a read
  sequence seq_done_read;
    done && avs_read;
  endsequence

  // Change of a tracked level sets its flag at that edge
  property p_change_sets(int b);
    $past(bankReady) && $changed(liveQ[b]) |-> flags[b];
  endproperty
  // Power and scaler flag on a rise only
  property p_rise_sets(int b);
    $past(bankReady) && $rose(liveQ[b]) |-> flags[b];
  endproperty

  // Pin and enables
  // The pin value never leaves low; only its enable follows the flags
  a_pin_open_drain: assert property (irqPinOut == 1'b0 &&
                                     irqPinOe == $past(nxt_st.irqOe))
    else $error("interrupt pin not open drain or wrong enable");

  a_mask_gates_pin: assert property ((flags & st_ff.mask) == '0 |=> !irqPinOe)
    else $error("disabled flags drove the pin");

  a_mask_bits_clean: assert property ((st_ff.mask & ~vdec_irq_pkg::USED_BITS) == '0)
    else $error("enable set where no flag exists");

  // Enables leave their reset value only by a host write
  a_mask_only_write: assert property ($changed(st_ff.mask) |-> $past(done) && $past(avs_write))
    else $error("enables changed without a host write");

  // Source flags; a multi-bit field is watched at its top bit
  a_power_flag: assert property (p_rise_sets(vdec_irq_pkg::BIT_POWER))
    else $error("power fail did not set flag");

  a_interlace_flag: assert property (p_change_sets(vdec_irq_pkg::BIT_INTERLACE))
    else $error("interlace change did not set flag");

  a_hlock_flag: assert property (p_change_sets(vdec_irq_pkg::BIT_HLOCK))
    else $error("horizontal lock change did not set flag");

  a_vlock_flag: assert property (p_change_sets(vdec_irq_pkg::BIT_VLOCK))
    else $error("vertical lock change did not set flag");

  a_field_flag: assert property (p_change_sets(vdec_irq_pkg::BIT_FIELD))
    else $error("field rate change did not set flag");

  a_capready_flag: assert property (p_change_sets(vdec_irq_pkg::BIT_CAPREADY))
    else $error("capture readiness change did not set flag");

  a_colour_flags: assert property (p_change_sets(vdec_irq_pkg::BIT_COLOUR + 1))
    else $error("colour standard change did not set flag");

  a_copyprot_flags: assert property (p_change_sets(vdec_irq_pkg::BIT_COPY_C))
    else $error("copy protection change did not set flag");

  a_vps_flag: assert property (p_change_sets(vdec_irq_pkg::BIT_VPS))
    else $error("VPS change did not set flag");

  a_wide_flag: assert property (p_change_sets(vdec_irq_pkg::BIT_WIDE))
    else $error("widescreen change did not set flag");

  a_caption_flag: assert property (p_change_sets(vdec_irq_pkg::BIT_CAPTION))
    else $error("caption change did not set flag");

  a_scaler_flag: assert property (p_rise_sets(vdec_irq_pkg::BIT_SCALER))
    else $error("scaler error did not set flag");

  // Reads
  // Read data is fetched on the taken edge and stands at completion
  a_status_live: assert property (seq_status_take(0) ##1 1'b1 |-> avs_readdata[7:0] == $past(liveQ[7:0]))
    else $error("status read did not return live state");

  // Upper bits of every register read are zero
  a_upper_zero: assert property (avs_readdata[31:8] == 24'h00_0000)
    else $error("read data above eight bits not zero");

  // Clearing
  // Only the own status read clears; other reads leave flags alone
  a_flag_holds: assert property (flags[vdec_irq_pkg::BIT_VPS] && !clrVec[vdec_irq_pkg::BIT_VPS] |=> flags[vdec_irq_pkg::BIT_VPS])
    else $error("flag cleared without its status read");

  a_pend_no_clear: assert property (done && grp != vdec_irq_pkg::GRP_STATUS |-> clrVec == '0)
    else $error("flags cleared by a read of another group");

  // Bits that changed at the clearing edge are set again and stay
  a_read_clears: assert property (seq_status_take(1) ##1 seq_done_read |=>
                                  (flags[15:8] & ~(liveQ[15:8] ^ $past(liveQ[15:8]))) == 8'h00)
    else $error("status read did not clear its flags");

  // Set over clear: the trigger at the clearing edge shows in liveQ one edge later
  a_set_wins: assert property ((clrVec[vdec_irq_pkg::BIT_HLOCK] && bankReady) ##1
                               $changed(liveQ[vdec_irq_pkg::BIT_HLOCK]) |-> flags[vdec_irq_pkg::BIT_HLOCK])
    else $error("new trigger lost during status read");
endmodule
`default_nettype wire

// *** tb/host_model.sv ***
/*
  Host controller model: Avalon-MM master tasks plus the pull-up on the
  open-drain request wire.
  Assumes one clock shared with the slave and a slave that answers with waitrequest.
*/
`default_nettype none
module host_model (
  // Clock
  input  wire logic        clk,
  // Avalon-MM master
  output logic      [5:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  // Open-drain request wire
  input  wire logic        irqPinOut,
  input  wire logic        irqPinOe,
  output logic             irqLevelN,
  // Status of the model
  output logic             timedOut
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Wire level
  // ------------------------------------------------------------
  // Pull-up: a released pin reads high, only the driver pulls low
  assign irqLevelN = irqPinOe ? irqPinOut : 1'h1;

  // Idle bus at time zero
  initial begin
    address    = 6'h00;
    read       = 1'h0;
    write      = 1'h0;
    writedata  = 32'h0;
    byteenable = 4'hF;
    timedOut   = 1'h0;
  end

  // ------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------
  // One transfer; the wait length is left to the slave, bounded only as a guard
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address    <= a;
    read       <= ~wr;
    write      <= wr;
    writedata  <= d;
    byteenable <= be;
    // Each rising edge samples waitrequest; the edge that sees it low completes
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 50);
    if (n >= 50) timedOut = 1'h1;
    q = readdata;
    read      <= 1'h0;
    write     <= 1'h0;
    // Released data shows no stale value
    writedata <= ~d;
  endtask

  // Service: reading only the enabled status registers is enough
  task automatic service(input logic [3:0] en);
    logic [31:0] q;
    for (int k = 0; k < 4; k++) if (en[k]) xfer(1'h0, 6'(k * 4), 32'h0, 4'hF, q);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/*
  Self-checking bench of the interrupt flag block: register access,
  per-source flagging, clear-on-read, pin behaviour and set-over-clear.
  Assumes the host model drives the bus and pulls up the request wire.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk = 1'h0;     // 200 MHz
  logic        rst_n = 1'h0;   // Device reset
  logic [31:0] src = 32'h0;    // Source levels in flag-vector layout
  logic [5:0]  address;
  logic        read, write, waitrequest, irqPinOut, irqPinOe, irqLevelN, hostTimeout;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  int          fails = 0;
  int          n_checks = 0;
  int          bits[15] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 16, 17, 18, 24};

  always #2.5 clk = ~clk;

  vdec_irq_flags i_vdec_irq_flags (
    .clk(clk), .rst_n(rst_n), .avs_address(address), .avs_read(read), .avs_write(write),
    .avs_writedata(writedata), .avs_byteenable(byteenable), .avs_readdata(readdata),
    .avs_waitrequest(waitrequest), .powerFail(src[7]), .interlaced(src[0]),
    .horizLocked(src[1]), .vertLocked(src[2]), .field60Hz(src[3]), .captureReady(src[4]),
    .colourStandard(src[6:5]), .copyProtLevel(src[10:8]), .vpsFound(src[16]),
    .widescreenFound(src[17]), .captionFound(src[18]), .scalerFormatError(src[24]),
    .irqPinOut(irqPinOut), .irqPinOe(irqPinOe));

  host_model u_host (
    .clk(clk), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .irqPinOut(irqPinOut), .irqPinOe(irqPinOe), .irqLevelN(irqLevelN), .timedOut(hostTimeout));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Address of register k in a group
  function automatic logic [5:0] adr(input logic [1:0] grp, input int k);
    return {grp, 2'(k), 2'h0};
  endfunction

  // Live status of register k as the host should see it
  function automatic logic [31:0] live(input int k);
    logic [31:0] v;
    v = src & vdec_irq_pkg::USED_BITS;
    return 32'(v[k*8+:8]);
  endfunction

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    u_host.xfer(1'h0, a, 32'h0, 4'hF, q);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    u_host.xfer(1'h1, a, d, be, q);
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    if (hostTimeout) fails++;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog: the tests need about 750 cycles
  initial begin
    #150000;
    fails++;
    wrap_up;
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q, m, u;
    int b, k, o;
    logic fl;
    void'($urandom(97));
    u = vdec_irq_pkg::USED_BITS;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    // Reset state: pin released, all enables and flags clear
    `CHK("pin at reset", 1'h1, irqLevelN)
    for (k = 0; k < 4; k++) begin
      rd(adr(vdec_irq_pkg::GRP_MASK, k), q);
      `CHK("mask reset", 32'h0, q)
      rd(adr(vdec_irq_pkg::GRP_PEND, k), q);
      `CHK("pending reset", 32'h0, q)
    end
    $display("test reset finished");
    // Enables: random write, lane-0-off write ignored, unused bits read zero
    for (k = 0; k < 4; k++) begin
      m = $urandom;
      wr(adr(vdec_irq_pkg::GRP_MASK, k), m, 4'hF);
      wr(adr(vdec_irq_pkg::GRP_MASK, k), ~m, 4'hE);
      rd(adr(vdec_irq_pkg::GRP_MASK, k), q);
      `CHK("mask readback", 32'(m[7:0] & u[k*8+:8]), q)
      wr(adr(vdec_irq_pkg::GRP_MASK, k), 32'h0, 4'hF);
    end
    // Unmapped and unaligned places read zero
    wr(6'h30, 32'hFF, 4'hF);
    rd(6'h30, q);
    `CHK("unmapped read", 32'h0, q)
    rd(6'h21, q);
    `CHK("unaligned read", 32'h0, q)
    $display("test registers finished");
    // Every source: first change with its enable on, second with it off
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 15; i++) begin
        b = bits[i];
        k = b / 8;
        wr(adr(vdec_irq_pkg::GRP_MASK, k), (p == 0) ? 32'(1 << (b % 8)) : 32'h0, 4'hF);
        src[b] <= ~src[b];
        // Power and scaler sources flag on a rise only
        fl = ~vdec_irq_pkg::RISE_ONLY[b] | (p == 0);
        repeat (3) @(posedge clk);
        `CHK("pin level", ~(fl & (p == 0)), irqLevelN)
        rd(adr(vdec_irq_pkg::GRP_PEND, k), q);
        `CHK("pending flag", {31'h0, fl} << (b % 8), q)
        o = (k + 1 + $urandom_range(2)) % 4;
        rd(adr(vdec_irq_pkg::GRP_STATUS, o), q);
        rd(adr(vdec_irq_pkg::GRP_PEND, k), q);
        `CHK("kept by other read", {31'h0, fl} << (b % 8), q)
        rd(adr(vdec_irq_pkg::GRP_STATUS, k), q);
        `CHK("live status", live(k), q)
        rd(adr(vdec_irq_pkg::GRP_PEND, k), q);
        `CHK("cleared by read", 32'h0, q)
        `CHK("pin after clear", 1'h1, irqLevelN)
      end
    end
    $display("test sources finished");
    // New trigger on the clearing edge keeps the flag
    wr(adr(vdec_irq_pkg::GRP_MASK, 0), 32'h02, 4'hF);
    src[1] <= ~src[1];
    repeat (3) @(posedge clk);
    fork
      rd(adr(vdec_irq_pkg::GRP_STATUS, 0), q);
      begin
        repeat (2) @(posedge clk);
        src[1] <= ~src[1];
      end
    join
    rd(adr(vdec_irq_pkg::GRP_PEND, 0), q);
    `CHK("set beats clear", 32'h02, q)
    `CHK("pin still low", 1'h0, irqLevelN)
    u_host.service(4'h1);
    // The pin is released one edge after the clearing edge
    repeat (2) @(posedge clk);
    `CHK("pin after service", 1'h1, irqLevelN)
    $display("test same-edge trigger finished");
    wrap_up;
  end
endmodule
`default_nettype wire
